//--- core/rmp_pkg.sv
`default_nettype none
package rmp_pkg;
  // ----------------------------------------
  // register byte offsets (word aligned)
  // ----------------------------------------
  localparam logic [7:0] off_type  = 8'h00; // unit type, read only
  localparam logic [7:0] off_ctrl  = 8'h04; // unit enable, privdef
  localparam logic [7:0] off_index = 8'h08; // region_index_reg
  localparam logic [7:0] off_base  = 8'h0c; // region_base_reg
  localparam logic [7:0] off_attr  = 8'h10; // region_attr_size_reg
  localparam logic [7:0] off_alias_last = 8'h28; // last alias attr
  localparam logic [7:0] off_fstat = 8'h40; // fault status, w1c
  localparam logic [7:0] off_faddr = 8'h44; // fault address
  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int base_valid_bit = 4;  // region-select flag in base
  localparam int attr_en_bit    = 0;
  localparam int attr_size_lo   = 1;  // size field [5:1]
  localparam int attr_srd_lo    = 8;  // subregion_disable_field [15:8]
  localparam int attr_b_bit     = 16;
  localparam int attr_c_bit     = 17;
  localparam int attr_s_bit     = 18;
  localparam int attr_tex_lo    = 19; // memory_type_ext_field [21:19]
  localparam int attr_ap_lo     = 24; // access_permission_field [26:24]
  localparam int attr_xn_bit    = 28; // no_execute_bit
  localparam logic [31:0] type_value = 32'h0000_0800; // eight regions
  localparam logic [31:0] reset_word = 32'h0000_0000;
  localparam int num_regions = 8;
  localparam logic [4:0] min_size_code = 5'h04; // 32 bytes
  localparam logic [4:0] srd_size_code = 5'h07; // 256 bytes and up
  // fault status bits
  localparam int fs_iacc = 0; // instruction access violation
  localparam int fs_dacc = 1; // data access violation
  localparam int fs_bg   = 2; // background privilege fault
  localparam int fs_addr_valid = 7;
  // ----------------------------------------
  // decoded memory kind
  // ----------------------------------------
  typedef enum logic [1:0] {
    rmp_strong, rmp_device, rmp_normal, rmp_reserved
  } rmp_mem_t;
endpackage
`default_nettype wire

//--- core/rmp_region_if.sv
`default_nettype none
// carries one region's settings from the register file to a matcher
interface rmp_region_if;
  logic [26:0] base_hi; // address bits 31:5
  logic [31:0] attr;    // attribute-and-size word
  logic        hit;     // address inside an enabled subregion
  modport regs  (output base_hi, output attr, input hit);
  modport match (input base_hi, input attr, output hit);
endinterface
`default_nettype wire

//--- core/rmp_region_match.sv
`default_nettype none
module rmp_region_match (
  // address under check
  input  wire logic [31:0] addr,
  // region settings
  rmp_region_if.match      rgn
);
  logic [4:0]  size_code; // region size = 2^(code+1) bytes
  logic [31:0] mask;      // ones over the offset inside the region
  logic [2:0]  sub;       // subregion index of addr
  logic        in_range;

  // ----------------------------------------
  // range and subregion match
  // ----------------------------------------
  always_comb begin
    size_code = rgn.attr[rmp_pkg::attr_size_lo +: 5];
    if (size_code < rmp_pkg::min_size_code) begin
      size_code = rmp_pkg::min_size_code; // smaller sizes not supported
    end
    mask = (32'h0000_0002 << size_code) - 32'h0000_0001;
    // base is aligned to the size by ignoring offset bits [R25]
    in_range = ((addr & ~mask) == ({rgn.base_hi, 5'h00} & ~mask));
    sub = 3'(addr >> (size_code - 5'h02)); // top three offset bits
    rgn.hit = rgn.attr[rmp_pkg::attr_en_bit] && in_range; // [R25]
    // small regions have no subregions; field assumed zero [R13]
    if (size_code >= rmp_pkg::srd_size_code) begin // [R10]
      if (rgn.attr[rmp_pkg::attr_srd_lo + sub]) begin // [R11]
        rgn.hit = 1'b0; // disabled, lower regions may match [R12]
      end
    end
  end
endmodule
`default_nettype wire

//--- core/rmp_unit.sv
`default_nettype none
// Overview of operation
// [R1] eight regions plus privileged background region
// [R2] highest numbered matching region wins
// [R3] background: default map, privileged only
// [R4] fetches and data share one region map
// [R5] prohibited access raises memory-management fault
// [R6] word access only; attr also byte/halfword
// [R7] unaligned register accesses are refused
// [R8] three alias base/attr pairs follow primary
// [R9] base write with flag loads region index
// [R10] regions of 256 bytes split into eight
// [R11] srd bit disables matching subregion, lsb lowest
// [R12] disabled subregion falls to other region, else fault; code passes privileged access there when privdef is set
// [R13] software keeps srd zero on small regions
// [R14] permission and no-execute violations fault
// [R15] tex 000: strongly ordered or device
// [R16] tex 000 with c: normal write-through
// [R17] tex 001: noncacheable, write-back or reserved
// [R18] tex 1xx: normal cached, outer/inner policies
// [R19] shareability ignored for ordered, device, reserved
// [R20] attributes exported only, no behaviour change
// [R21] software disables region before reprogramming
// [R22] software issues barriers after changes
// [R23] access permission field decode table
// [R24] violation cause recorded in fault status
// [R25] match needs enable and aligned base range
// [R26] reset leaves unit and regions disabled
module rmp_unit (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // access check request from the core
  input  wire logic        chk_valid,
  input  wire logic [31:0] chk_addr,
  input  wire logic        chk_write,
  input  wire logic        chk_fetch,
  input  wire logic        chk_priv,
  // check result, one cycle after the request
  output logic             chk_done,
  output logic             chk_fault,
  output logic             mm_fault_pulse,
  output logic [1:0]       attr_mem_kind,
  output logic             attr_share,
  output logic [3:0]       attr_cache
);
  // ----------------------------------------
  // region storage
  // ----------------------------------------
  logic [26:0] base_mem [rmp_pkg::num_regions]; // base bits [R1]
  logic [31:0] attr_mem [rmp_pkg::num_regions]; // attr and size words
  logic [2:0]  region_index_reg;                // selected region
  logic        unit_en;                         // unit enable
  logic        privdef_en;                      // background enable
  logic [7:0]  fault_stat;                      // sticky fault causes
  logic [31:0] fault_addr;                      // last faulting data addr
  logic [7:0]  hits;                            // per-region hit

  // one matcher per region, all fed by the single address [R4]
  for (genvar g = 0; g < rmp_pkg::num_regions; g++) begin : g_rgn
    rmp_region_if rif ();
    assign rif.base_hi = base_mem[g];
    assign rif.attr    = attr_mem[g];
    assign hits[g]     = rif.hit;
    rmp_region_match u_match (
      .addr (chk_addr),
      .rgn  (rif.match)
    );
  end

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // register byte address of bus word
  function automatic logic [7:0] wa(input logic [7:0] a);
    return {a[7:2], 2'b00};
  endfunction

  // true for the primary base offset and the three alias base offsets [R8]
  function automatic logic is_base(input logic [7:0] a);
    return (a >= rmp_pkg::off_base) && (a <= rmp_pkg::off_alias_last)
      && (((a - rmp_pkg::off_base) & 8'h04) == 8'h00);
  endfunction

  function automatic logic is_attr(input logic [7:0] a);
    return (a >= rmp_pkg::off_attr) && (a <= rmp_pkg::off_alias_last)
      && (((a - rmp_pkg::off_attr) & 8'h04) == 8'h00);
  endfunction

  // permission check for one access [R23]
  function automatic logic perm_ok(input logic [2:0] ap,
                                   input logic pv, input logic wr);
    logic ok;
    ok = 1'b0;
    unique case (ap)
      3'h0: ok = 1'b0;                      // no access
      3'h1: ok = pv;                        // privileged r/w
      3'h2: ok = pv || !wr;                 // user read only
      3'h3: ok = 1'b1;                      // full access
      3'h4: ok = 1'b0;                      // reserved, refused
      3'h5: ok = pv && !wr;                 // privileged read only
      3'h6: ok = !wr;                       // read only for all
      3'h7: ok = !wr;
    endcase
    return ok;
  endfunction

  // ----------------------------------------
  // wishbone decode
  // ----------------------------------------
  logic       req;      // new request, not yet answered
  logic       word_ok;  // full aligned word
  logic       size_ok;  // access size legal for the target
  logic       mapped;
  logic [7:0] a;
  logic [2:0] tgt;      // region written by a base/attr access

  always_comb begin
    a   = wa(wb_adr_i);
    req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    word_ok = (wb_sel_i == 4'hf);
    mapped = (a == rmp_pkg::off_type) || (a == rmp_pkg::off_ctrl)
      || (a == rmp_pkg::off_index) || is_base(a) || is_attr(a)
      || (a == rmp_pkg::off_fstat) || (a == rmp_pkg::off_faddr);
    // an address off a word boundary is never a register [R7]
    mapped = mapped && (wb_adr_i[1:0] == 2'b00); // [R7]
    // attr takes byte, aligned halfword or word; all else word [R6]
    if (is_attr(a)) begin
      size_ok = (wb_sel_i == 4'h1) || (wb_sel_i == 4'h2)
        || (wb_sel_i == 4'h4) || (wb_sel_i == 4'h8)
        || (wb_sel_i == 4'h3) || (wb_sel_i == 4'hc) || word_ok; // [R7]
    end else begin
      size_ok = word_ok; // [R6]
    end
    // alias pairs all address the currently selected region [R8]
    tgt = region_index_reg;
  end

  // ----------------------------------------
  // bus answer: ack in the cycle after the strobe, err if refused
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end else begin
      wb_ack_o <= req && mapped && size_ok;
      wb_err_o <= req && !(mapped && size_ok); // [R7]
    end
  end

  // read data, registered with the ack
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wb_dat_o <= rmp_pkg::reset_word;
    end else if (req && !wb_we_i) begin
      if (a == rmp_pkg::off_type) begin
        wb_dat_o <= rmp_pkg::type_value;
      end else if (a == rmp_pkg::off_ctrl) begin
        wb_dat_o <= {30'h0, privdef_en, unit_en};
      end else if (a == rmp_pkg::off_index) begin
        wb_dat_o <= {29'h0, region_index_reg};
      end else if (is_base(a)) begin
        wb_dat_o <= {base_mem[tgt], 2'b00, region_index_reg};
      end else if (is_attr(a)) begin
        wb_dat_o <= attr_mem[tgt];
      end else if (a == rmp_pkg::off_fstat) begin
        wb_dat_o <= {24'h0, fault_stat};
      end else if (a == rmp_pkg::off_faddr) begin
        wb_dat_o <= fault_addr;
      end else begin
        wb_dat_o <= rmp_pkg::reset_word; // unmapped reads zero
      end
    end
  end

  logic wr_ok; // write accepted this cycle
  assign wr_ok = req && wb_we_i && mapped && size_ok;

  // control register; reset leaves the unit off [R26]
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      unit_en    <= 1'b0; // [R26]
      privdef_en <= 1'b0;
    end else if (wr_ok && a == rmp_pkg::off_ctrl) begin
      unit_en    <= wb_dat_i[0];
      privdef_en <= wb_dat_i[1];
    end
  end

  // region index: direct write or base write with flag set [R9]
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      region_index_reg <= 3'h0;
    end else if (wr_ok && a == rmp_pkg::off_index) begin
      region_index_reg <= wb_dat_i[2:0];
    end else if (wr_ok && is_base(a)
                 && wb_dat_i[rmp_pkg::base_valid_bit]) begin
      region_index_reg <= wb_dat_i[2:0]; // [R9]
    end
  end

  // region base and attributes, byte-lane writes on attr [R6]
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < rmp_pkg::num_regions; i++) begin
        base_mem[i] <= 27'h0;
        attr_mem[i] <= rmp_pkg::reset_word; // all regions off [R26]
      end
    end else if (wr_ok && is_base(a)) begin
      // flagged write targets the region named in the data [R9]
      if (wb_dat_i[rmp_pkg::base_valid_bit]) begin
        base_mem[wb_dat_i[2:0]] <= wb_dat_i[31:5];
      end else begin
        base_mem[tgt] <= wb_dat_i[31:5];
      end
    end else if (wr_ok && is_attr(a)) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          attr_mem[tgt][8*b +: 8] <= wb_dat_i[8*b +: 8];
        end
      end
    end
  end

  // ----------------------------------------
  // access check
  // ----------------------------------------
  logic       any_hit;
  logic [2:0] win;     // winning region number
  logic [31:0] wattr;  // winning attributes
  logic       allow;
  logic       bg_fault;

  // the highest matching region number wins [R2]
  always_comb begin
    any_hit = 1'b0;
    win = 3'h0;
    for (int i = 0; i < rmp_pkg::num_regions; i++) begin
      if (hits[i]) begin
        any_hit = 1'b1;
        win = 3'(i); // later, higher index overrides [R2]
      end
    end
    wattr = attr_mem[win];
    bg_fault = 1'b0;
    if (!unit_en) begin
      allow = 1'b1; // default map while disabled [R26]
    end else if (any_hit) begin
      // permission and no-execute checked together [R14]
      allow = perm_ok(wattr[rmp_pkg::attr_ap_lo +: 3], chk_priv,
                      chk_write)
        && !(chk_fetch && wattr[rmp_pkg::attr_xn_bit]); // [R14]
    end else begin
      // background region: privileged only, if enabled [R3]
      allow = chk_priv && privdef_en; // [R3]
      bg_fault = !allow; // uncovered address faults unless privileged with privdef set [R12]
    end
  end

  // result and fault pulse, one cycle after request [R5]
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      chk_done       <= 1'b0;
      chk_fault      <= 1'b0;
      mm_fault_pulse <= 1'b0;
    end else begin
      chk_done       <= chk_valid;
      chk_fault      <= chk_valid && !allow;
      mm_fault_pulse <= chk_valid && !allow; // [R5]
    end
  end

  // decoded attributes, exported only [R20]
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      attr_mem_kind <= 2'(rmp_pkg::rmp_strong);
      attr_share    <= 1'b1;
      attr_cache    <= 4'h0;
    end else if (chk_valid) begin
      logic [2:0] tx;
      logic       c;
      logic       bb;
      tx = wattr[rmp_pkg::attr_tex_lo +: 3];
      c  = wattr[rmp_pkg::attr_c_bit];
      bb = wattr[rmp_pkg::attr_b_bit];
      attr_share <= wattr[rmp_pkg::attr_s_bit];
      attr_cache <= 4'h0;
      if (!unit_en || !any_hit) begin
        attr_mem_kind <= 2'(rmp_pkg::rmp_normal); // default map [R3]
      end else if (tx[2]) begin
        attr_mem_kind <= 2'(rmp_pkg::rmp_normal); // [R18]
        attr_cache    <= {tx[1:0], c, bb}; // outer, inner [R18]
      end else if (tx == 3'h0 && !c) begin
        attr_mem_kind <= bb ? 2'(rmp_pkg::rmp_device)
                            : 2'(rmp_pkg::rmp_strong); // [R15]
        attr_share    <= 1'b1; // s bit ignored [R19]
      end else if (tx == 3'h0) begin
        attr_mem_kind <= 2'(rmp_pkg::rmp_normal); // write-through [R16]
        attr_cache    <= 4'ha;
      end else if (tx == 3'h1 && c == bb) begin
        attr_mem_kind <= 2'(rmp_pkg::rmp_normal); // [R17]
        attr_cache    <= c ? 4'h5 : 4'h0;
      end else if (tx == 3'h2 && !c && !bb) begin
        attr_mem_kind <= 2'(rmp_pkg::rmp_device); // nonshared device
        attr_share    <= 1'b0;
      end else begin
        attr_mem_kind <= 2'(rmp_pkg::rmp_reserved); // [R17]
        attr_share    <= 1'b0; // s bit ignored [R19]
      end
    end
  end

  // fault status: set wins over write-one-to-clear [R24]
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fault_stat <= 8'h00;
      fault_addr <= rmp_pkg::reset_word;
    end else begin
      logic [7:0] nx;
      nx = fault_stat;
      if (wr_ok && a == rmp_pkg::off_fstat) begin
        nx = nx & ~wb_dat_i[7:0];
      end
      if (chk_valid && !allow) begin
        nx[chk_fetch ? rmp_pkg::fs_iacc : rmp_pkg::fs_dacc] = 1'b1;
        if (bg_fault) begin
          nx[rmp_pkg::fs_bg] = 1'b1;
        end
        if (!chk_fetch) begin
          nx[rmp_pkg::fs_addr_valid] = 1'b1;
          fault_addr <= chk_addr;
        end
      end
      fault_stat <= nx; // [R24]
    end
  end
endmodule
`default_nettype wire

//--- bench/rmp_core_model.sv
`default_nettype none
// -------------------------------------------
// core side: issues one check and takes its answer
// -------------------------------------------
module rmp_core_model (
  // clock
  input  wire logic        clk_sys,
  // check request towards the unit
  output logic             chk_valid,
  output logic [31:0]      chk_addr,
  output logic             chk_write,
  output logic             chk_fetch,
  output logic             chk_priv,
  // answer from the unit
  input  wire logic        chk_done,
  input  wire logic        chk_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle request lines at time zero
  initial begin
    chk_valid = 1'b0;
    chk_addr  = 32'h0;
    chk_write = 1'b0;
    chk_fetch = 1'b0;
    chk_priv  = 1'b0;
  end
  // gap + 1 idle cycles first, so a slow core can be mimicked
  task automatic access(input logic [31:0] a, input logic w, f, p,
                        input int gap, output logic d, q);
    repeat (gap + 1) @(posedge clk_sys);
    chk_valid <= 1'b1;
    chk_addr  <= a;
    chk_write <= w;
    chk_fetch <= f;
    chk_priv  <= p;
    @(posedge clk_sys);
    chk_valid <= 1'b0;
    // released address does not linger on the lines
    chk_addr  <= ~a;
    @(posedge clk_sys);
    d = chk_done;
    q = chk_fault;
  endtask
endmodule
`default_nettype wire

//--- bench/rmp_unit_monitor.sv
`default_nettype none
module rmp_unit_monitor (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // register bus
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_ack_o,
  input  wire logic        wb_err_o,
  // check port
  input  wire logic        chk_valid,
  input  wire logic        chk_done,
  input  wire logic        chk_fault,
  input  wire logic        mm_fault_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // a request not yet answered
  wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire logic ans = wb_ack_o || wb_err_o;
  property p_answer; req |=> wb_ack_o ^ wb_err_o; endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_once; ans |=> !ans; endproperty
  a_once: assert property (p_once) else $error("answer held");
  property p_unal; req && wb_adr_i[1:0] != 2'h0 |=> wb_err_o; endproperty
  a_unal: assert property (p_unal) else $error("unaligned taken");
  property p_word;
    req && wb_adr_i == rmp_pkg::off_ctrl && wb_sel_i != 4'hf |=> wb_err_o;
  endproperty
  a_word: assert property (p_word) else $error("narrow ctrl taken");
  property p_byte;
    req && wb_adr_i == rmp_pkg::off_attr && wb_sel_i == 4'h8 |=> wb_ack_o;
  endproperty
  a_byte: assert property (p_byte) else $error("attr byte refused");
  property p_done; chk_valid |=> chk_done; endproperty
  a_done: assert property (p_done) else $error("check unanswered");
  property p_cause; chk_done |-> $past(chk_valid); endproperty
  a_cause: assert property (p_cause) else $error("stray done");
  property p_mm; chk_fault |-> mm_fault_pulse && chk_done; endproperty
  a_mm: assert property (p_mm) else $error("fault not raised");
  property p_quiet; $fell(rst) |-> !chk_done && !ans; endproperty
  a_quiet: assert property (p_quiet) else $error("busy after reset");
  c_fault: cover property (chk_fault);
  c_err: cover property (wb_err_o);
  c_pass: cover property (chk_done && !chk_fault);
endmodule
bind rmp_unit rmp_unit_monitor mon (.clk_sys, .rst, .wb_cyc_i, .wb_stb_i,
  .wb_adr_i, .wb_sel_i, .wb_ack_o, .wb_err_o, .chk_valid, .chk_done,
  .chk_fault, .mm_fault_pulse);
`default_nettype wire

//--- bench/tb_top.sv
`default_nettype none
`define CHK(nm, ex, got) begin \
  samples_checked++; \
  if ((got) !== (ex)) begin \
    failures++; \
    $display("Error %s expected %h seen %h", nm, ex, got); \
  end \
end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // -------------------------------------------
  // signals
  // -------------------------------------------
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, chk_addr;
  logic wb_ack_o, wb_err_o, chk_valid, chk_write, chk_fetch, chk_priv;
  logic chk_done, chk_fault, mm_fault_pulse, attr_share;
  logic [1:0] attr_mem_kind;
  logic [3:0] attr_cache;
  int failures = 0, samples_checked = 0;
  // access masks indexed by permission code: pr/un read/write allowed
  logic [7:0] ok_pr = 8'hee, ok_pw = 8'h0e, ok_ur = 8'hcc, ok_uw = 8'h08;
  // type lane bytes {ext,s,c,b} and expected decode
  logic [7:0] tx_b[7] = '{8'h00, 8'h01, 8'h0c, 8'h0b, 8'h09, 8'h2a, 8'h10};
  logic [1:0] tx_k[7] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h2, 2'h1};
  logic [3:0] tx_c[7] = '{4'h0, 4'h0, 4'h0, 4'h5, 4'h0, 4'h6, 4'h0};
  logic       tx_s[7] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  initial forever #4 clk_sys = ~clk_sys;
  rmp_unit dut (.clk_sys, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .chk_valid,
    .chk_addr, .chk_write, .chk_fetch, .chk_priv, .chk_done, .chk_fault,
    .mm_fault_pulse, .attr_mem_kind, .attr_share, .attr_cache);
  rmp_core_model core (.clk_sys, .chk_valid, .chk_addr, .chk_write,
    .chk_fetch, .chk_priv, .chk_done, .chk_fault);
  // -------------------------------------------
  // tasks
  // -------------------------------------------
  task automatic end_of_test();
    if (failures == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one classic cycle, bounded wait for ack or err
  task automatic xfer(input logic [7:0] a, input logic [3:0] s,
    input logic w, input logic [31:0] d, input logic [31:0] ex, input logic ee);
    int n;
    n = 0;
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} <= {2'h3, w, a, s};
    wb_dat_i <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      end_of_test();
    end
    `CHK("wb_err_o", ee, wb_err_o)
    if (!w && !ee) `CHK("wb_dat_o", ex, wb_dat_o)
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  task automatic acc(input logic [31:0] a, input logic w, f, p, e);
    logic d, q;
    core.access(a, w, f, p, 0, d, q);
    `CHK("chk_done", 1'b1, d)
    `CHK("chk_fault", e, q)
    // the fault pulse stands in the same cycle as the answer
    `CHK("mm_fault_pulse", e, mm_fault_pulse)
  endtask
  // -------------------------------------------
  // sequence
  // -------------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    `CHK("attr_share", 1'b1, attr_share)
    xfer(rmp_pkg::off_type, 4'hf, 0, 0, 32'h800, 0);
    xfer(rmp_pkg::off_ctrl, 4'hf, 0, 0, 32'h0, 0);
    acc(32'h2000_1000, 1, 0, 0, 0);
    `CHK("attr_mem_kind", 2'h2, attr_mem_kind)
    // regions start disabled, so no disable step is needed first
    xfer(rmp_pkg::off_index, 4'hf, 1, 0, 0, 0);
    xfer(rmp_pkg::off_base, 4'hf, 1, 32'h2000_0000, 0, 0);
    xfer(rmp_pkg::off_attr, 4'hf, 1, 32'h0306_0117, 0, 0);
    xfer(8'h14, 4'hf, 1, 32'h2000_0011, 0, 0);
    xfer(8'h18, 4'hf, 1, 32'h1601_000f, 0, 0);
    xfer(rmp_pkg::off_index, 4'hf, 0, 0, 32'h1, 0);
    xfer(rmp_pkg::off_ctrl, 4'hf, 1, 32'h3, 0, 0);
    acc(32'h2000_0010, 0, 0, 0, 0);
    `CHK("attr_mem_kind", 2'h1, attr_mem_kind)
    acc(32'h2000_0010, 1, 0, 0, 1);
    acc(32'h2000_0010, 0, 1, 0, 1);
    acc(32'h2000_0200, 1, 0, 0, 0);
    `CHK("attr_cache", 4'ha, attr_cache)
    `CHK("attr_share", 1'b1, attr_share)
    acc(32'h2000_0180, 0, 0, 0, 1);
    acc(32'h2000_0180, 0, 0, 1, 0);
    acc(32'h2000_0ffc, 0, 0, 0, 0);
    acc(32'h2000_1000, 0, 0, 1, 0);
    acc(32'h2000_1000, 0, 0, 0, 1);
    xfer(rmp_pkg::off_fstat, 4'hf, 0, 0, 32'h87, 0);
    xfer(rmp_pkg::off_faddr, 4'hf, 0, 0, 32'h2000_1000, 0);
    xfer(rmp_pkg::off_fstat, 4'hf, 1, 32'hff, 0, 0);
    xfer(rmp_pkg::off_fstat, 4'hf, 0, 0, 32'h0, 0);
    xfer(rmp_pkg::off_ctrl, 4'hf, 1, 32'h1, 0, 0);
    acc(32'h2000_1000, 0, 0, 1, 1);
    // checks start only once the setting write is acknowledged
    xfer(rmp_pkg::off_ctrl, 4'hf, 1, 32'h3, 0, 0);
    // every permission code, written through the top byte lane
    for (int ap = 0; ap < 8; ap++) begin
      xfer(rmp_pkg::off_attr, 4'h8, 1, 32'(ap) << 24, 0, 0);
      acc(32'h2000_0010, 0, 0, 1, !ok_pr[ap]);
      acc(32'h2000_0010, 1, 0, 1, !ok_pw[ap]);
      acc(32'h2000_0010, 0, 0, 0, !ok_ur[ap]);
      acc(32'h2000_0010, 1, 0, 0, !ok_uw[ap]);
    end
    // memory type decode; faults must not depend on it
    for (int i = 0; i < 7; i++) begin
      xfer(rmp_pkg::off_attr, 4'h4, 1, 32'(tx_b[i]) << 16, 0, 0);
      acc(32'h2000_0010, 0, 0, 0, 0);
      `CHK("attr_mem_kind", tx_k[i], attr_mem_kind)
      if (tx_k[i] == 2'h2) `CHK("attr_cache", tx_c[i], attr_cache)
      if (i != 4) `CHK("attr_share", tx_s[i], attr_share)
    end
    // refused accesses change nothing
    xfer(8'h30, 4'hf, 0, 0, 0, 1);
    xfer(8'h0a, 4'hf, 0, 0, 0, 1);
    xfer(rmp_pkg::off_ctrl, 4'h1, 1, 32'h0, 0, 1);
    xfer(rmp_pkg::off_attr, 4'h6, 1, 32'h0, 0, 1);
    xfer(rmp_pkg::off_ctrl, 4'hf, 0, 0, 32'h3, 0);
    // reset in mid-run returns to the open map
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    xfer(rmp_pkg::off_ctrl, 4'hf, 0, 0, 32'h0, 0);
    acc(32'h2000_0010, 1, 1, 0, 0);
    end_of_test();
  end
endmodule
`default_nettype wire
